// ==== logic/wpb_top.sv ====
// Wake-up, power button, supply-on and blink control
`timescale 1ns/10ps
`default_nettype none
module wpb_top #(
    parameter int DEBOUNCE_CYCLES = wpb_pkg::DEBOUNCE_CYCLES,
    parameter int HALF_PERIOD_CYCLES = wpb_pkg::HALF_PERIOD_CYCLES,
    parameter int RING_WINDOW_CYCLES = wpb_pkg::RING_WINDOW_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic supply_on_polarity_strap,
    input wire logic pin_config_strap_a,
    input wire logic pin_config_strap_b,
    input wire logic button_in,
    input wire logic ring_in,
    input wire logic sleep_state_a_in,
    input wire logic sleep_state_b_in,
    input wire logic standby_in_pin,
    input wire logic request_ack,
    input wire logic supply_enable,
    input wire logic [2:0] blink_sel_a,
    input wire logic [2:0] blink_sel_b,
    input wire logic [1:0] standby_out_value,
    output logic blink_out_a,
    output logic blink_out_b,
    output logic button_out,
    output logic supply_on_out,
    output logic supply_on_oe,
    output logic power_up_request,
    output logic standby_out_a,
    output logic standby_out_b,
    output logic standby_in,
    output logic sleep_a,
    output logic sleep_b,
    output logic power_mode
);
    logic button_clean;
    logic strap_pol;
    logic strap_pins;
    logic strap_taken;
    logic ring_s1;
    logic ring_s2;
    logic ring_prev;
    logic [1:0] sl_s1;
    logic [1:0] sl_s2;
    logic [2:0] sb_s1;
    logic [2:0] sb_s2;
    logic stby_s1;
    logic stby_s2;
    logic [31:0] tick_count;
    logic [4:0] phase;
    logic [31:0] ring_timer;
    logic [2:0] ring_pulses;
    logic wake_pending;
    logic [31:0] next_tick_count;
    logic [4:0] next_phase;
    logic [31:0] next_ring_timer;
    logic [2:0] next_ring_pulses;
    logic next_wake_pending;
    logic next_strap_pol;
    logic next_strap_pins;
    logic next_strap_taken;
    wpb_pkg::wpb_pins_type pins;
    wpb_pkg::wpb_pins_type next_pins;
    logic next_blink_a;
    logic next_blink_b;
    logic [2:0] next_standby;

    wpb_debounce #(.STABLE_CYCLES(DEBOUNCE_CYCLES)) u_debounce (
        .clock(clock),
        .rst(rst),
        .raw_in(button_in),
        .clean_out(button_clean)
    );

    function automatic logic blink_wave(input logic [2:0] sel,
                                        input logic [4:0] ph);
        case (wpb_pkg::wpb_blink_type'(sel))
            wpb_pkg::WPB_Q_HZ: blink_wave = ph[4];
            wpb_pkg::WPB_H_HZ: blink_wave = ph[3];
            wpb_pkg::WPB_1_HZ: blink_wave = ph[2];
            wpb_pkg::WPB_4_HZ: blink_wave = ph[0];
            wpb_pkg::WPB_ON: blink_wave = 1'h1;
            default: blink_wave = 1'h0;
        endcase
    endfunction

    always_comb begin
        next_tick_count = tick_count + 32'h1;
        next_phase = phase;
        if (tick_count >= 32'(HALF_PERIOD_CYCLES - 1)) begin
            next_tick_count = 32'h0;
            next_phase = phase + 5'h1;
        end
        next_blink_a = blink_wave(blink_sel_a, phase);
        next_blink_b = blink_wave(blink_sel_b, phase);
    end

    always_comb begin
        next_strap_taken = 1'h1;
        next_strap_pol = strap_pol;
        next_strap_pins = strap_pins;
        if (!strap_taken) begin
            next_strap_pol = sb_s2[0];
            next_strap_pins = sb_s2[1] | sb_s2[2];
        end
    end

    always_comb begin
        next_ring_timer = ring_timer;
        next_ring_pulses = ring_pulses;
        next_wake_pending = wake_pending;
        if (ring_pulses != 3'h0) begin
            if (ring_timer == 32'h0) begin
                next_ring_pulses = 3'h0;
            end else begin
                next_ring_timer = ring_timer - 32'h1;
            end
        end
        if (ring_prev && !ring_s2) begin
            if (ring_pulses == 3'h0) begin
                next_ring_timer = 32'(RING_WINDOW_CYCLES - 1);
            end
            next_ring_pulses = ring_pulses + 3'h1;
            if (ring_pulses + 3'h1 >= 3'(wpb_pkg::RING_PULSES)) begin
                next_ring_pulses = 3'h0;
                next_wake_pending = 1'h1;
            end
        end
        if (request_ack && !(ring_prev && !ring_s2 &&
            ring_pulses + 3'h1 >= 3'(wpb_pkg::RING_PULSES))) begin
            next_wake_pending = 1'h0;
        end
    end

    always_comb begin
        next_pins.power_up_request = !wake_pending;
        next_pins.button_out = strap_pins ? 1'h1 : button_clean;
        if (strap_pol) begin
            next_pins.supply_on_out = supply_enable;
            next_pins.supply_on_oe = !strap_pins;
        end else begin
            next_pins.supply_on_out = 1'h0;
            next_pins.supply_on_oe = supply_enable && !strap_pins;
        end
        next_standby[0] = strap_pins & standby_out_value[0];
        next_standby[1] = strap_pins & standby_out_value[1];
        next_standby[2] = strap_pins & stby_s2;
    end

    always_ff @(posedge clock) begin
        // Strap sync runs through reset so capture sees the pins
        sb_s1 <= {pin_config_strap_b, pin_config_strap_a,
                  supply_on_polarity_strap};
        sb_s2 <= sb_s1;
        if (rst) begin
            ring_s1 <= 1'h1;
            ring_s2 <= 1'h1;
            ring_prev <= 1'h1;
            sl_s1 <= 2'h0;
            sl_s2 <= 2'h0;
            stby_s1 <= 1'h0;
            stby_s2 <= 1'h0;
            tick_count <= 32'h0;
            phase <= 5'h0;
            ring_timer <= 32'h0;
            ring_pulses <= 3'h0;
            wake_pending <= 1'h0;
            strap_pol <= 1'h0;
            strap_pins <= 1'h0;
            strap_taken <= 1'h0;
            pins <= '{button_out: 1'h1, supply_on_out: 1'h0,
                      supply_on_oe: 1'h0, power_up_request: 1'h1};
            blink_out_a <= 1'h0;
            blink_out_b <= 1'h0;
            standby_out_a <= 1'h0;
            standby_out_b <= 1'h0;
            standby_in <= 1'h0;
            sleep_a <= 1'h0;
            sleep_b <= 1'h0;
            power_mode <= 1'h0;
        end else begin
            ring_s1 <= ring_in;
            ring_s2 <= ring_s1;
            ring_prev <= ring_s2;
            sl_s1 <= {sleep_state_b_in, sleep_state_a_in};
            sl_s2 <= sl_s1;
            stby_s1 <= standby_in_pin;
            stby_s2 <= stby_s1;
            tick_count <= next_tick_count;
            phase <= next_phase;
            ring_timer <= next_ring_timer;
            ring_pulses <= next_ring_pulses;
            wake_pending <= next_wake_pending;
            strap_pol <= next_strap_pol;
            strap_pins <= next_strap_pins;
            strap_taken <= next_strap_taken;
            pins <= next_pins;
            blink_out_a <= next_blink_a;
            blink_out_b <= next_blink_b;
            standby_out_a <= next_standby[0];
            standby_out_b <= next_standby[1];
            standby_in <= next_standby[2];
            sleep_a <= sl_s2[0];
            sleep_b <= strap_pins ? 1'h0 : sl_s2[1];
            power_mode <= next_strap_pol;
        end
    end

    assign button_out = pins.button_out;
    assign supply_on_out = pins.supply_on_out;
    assign supply_on_oe = pins.supply_on_oe;
    assign power_up_request = pins.power_up_request;
endmodule
`default_nettype wire

// ==== logic/wpb_pkg.sv ====
// Package for the wake and power button control block
package wpb_pkg;
    localparam int CLOCK_MHZ = 250;
    localparam int DEBOUNCE_MS = 16;
    localparam int DEBOUNCE_CYCLES = DEBOUNCE_MS * 1000 * CLOCK_MHZ;
    localparam int QUARTER_SEC_MS = 125;
    localparam int HALF_PERIOD_4HZ_MS = 125;
    localparam int HALF_PERIOD_CYCLES = HALF_PERIOD_4HZ_MS * 1000 * CLOCK_MHZ;
    localparam int RING_WINDOW_CYCLES = 500 * 1000 * CLOCK_MHZ;
    localparam int RING_PULSES = 3;
    localparam logic [2:0] BLINK_RESET = 3'h0;
    localparam logic BUTTON_RESET = 1'h1;

    typedef enum logic [2:0] {
        WPB_OFF, WPB_Q_HZ, WPB_H_HZ, WPB_1_HZ, WPB_4_HZ, WPB_ON
    } wpb_blink_type;

    typedef struct packed {
        logic button_out;
        logic supply_on_out;
        logic supply_on_oe;
        logic power_up_request;
    } wpb_pins_type;
endpackage

// ==== logic/wpb_debounce.sv ====
// Level debouncer with synchroniser
`timescale 1ns/10ps
`default_nettype none
module wpb_debounce #(
    parameter int STABLE_CYCLES = wpb_pkg::DEBOUNCE_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic raw_in,
    output logic clean_out
);
    logic sync_a;
    logic sync_b;
    logic [31:0] count;
    logic [31:0] next_count;
    logic next_clean_out;

    always_comb begin
        next_count = 32'h0;
        next_clean_out = clean_out;
        if (sync_b != clean_out) begin
            if (count >= 32'(STABLE_CYCLES - 1)) begin
                next_clean_out = sync_b;
            end else begin
                next_count = count + 32'h1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            sync_a <= wpb_pkg::BUTTON_RESET;
            sync_b <= wpb_pkg::BUTTON_RESET;
            count <= 32'h0;
            clean_out <= wpb_pkg::BUTTON_RESET;
        end else begin
            sync_a <= raw_in;
            sync_b <= sync_a;
            count <= next_count;
            clean_out <= next_clean_out;
        end
    end
endmodule
`default_nettype wire

// ==== tb/wpb_check_sva.sv ====
// Port assertions for the wake and power control block
`timescale 1ns/10ps
`default_nettype none
module wpb_check #(
    parameter int DEBOUNCE_CYCLES = wpb_pkg::DEBOUNCE_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic supply_on_polarity_strap,
    input wire logic pin_config_strap_a,
    input wire logic pin_config_strap_b,
    input wire logic button_in,
    input wire logic request_ack,
    input wire logic supply_enable,
    input wire logic [2:0] blink_sel_a,
    input wire logic [2:0] blink_sel_b,
    input wire logic blink_out_a,
    input wire logic blink_out_b,
    input wire logic button_out,
    input wire logic supply_on_out,
    input wire logic supply_on_oe,
    input wire logic power_up_request,
    input wire logic power_mode
);
    int stable_cnt;
    logic last_in, low_strap;
    assign low_strap = !pin_config_strap_a && !pin_config_strap_b;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // Cycles the raw button level has stayed unchanged
    always_ff @(posedge clock) begin
        last_in <= button_in;
        if (rst || button_in != last_in) begin
            stable_cnt <= 0;
        end else if (stable_cnt < 1000) begin
            stable_cnt <= stable_cnt + 1;
        end
    end
    a_off_dark: assert property (
        (blink_sel_a == 3'h0)[*4] |-> !blink_out_a)
        else $error("blink a lit while off");
    a_steady_lit: assert property (
        (blink_sel_b == 3'h5)[*4] |-> blink_out_b)
        else $error("blink b dark while steady");
    a_low_drain: assert property (
        (low_strap && !supply_on_polarity_strap && supply_enable)[*6]
        |-> supply_on_oe && !supply_on_out)
        else $error("active-low supply not open-drain low");
    a_high_push: assert property (
        (low_strap && supply_on_polarity_strap && supply_enable)[*6]
        |-> supply_on_oe && supply_on_out)
        else $error("active-high supply not driven high");
    a_mode_capture: assert property (
        $stable(supply_on_polarity_strap)[*4]
        |=> power_mode == supply_on_polarity_strap)
        else $error("polarity mode differs from strap");
    a_ack_release: assert property (
        $rose(power_up_request) |-> $past(request_ack, 2))
        else $error("request released without ack");
    a_request_hold: assert property (
        !power_up_request && !request_ack && !$past(request_ack)
        |=> !power_up_request)
        else $error("request dropped early");
    a_button_follow: assert property (
        low_strap && stable_cnt == DEBOUNCE_CYCLES + 8
        |-> button_out == button_in)
        else $error("button out not following stable input");
    a_pin_mode: assert property (
        (!low_strap)[*4] |-> !supply_on_oe && button_out)
        else $error("power pins active in standby mode");
endmodule
`default_nettype wire

// ==== tb/wpb_chipset_model.sv ====
// Chipset and sleep controller model
`timescale 1ns/10ps
`default_nettype none
module wpb_chipset_model (
    input wire logic clock,
    input wire logic power_up_request,
    input wire logic [2:0] sleep_code,
    input var int ack_delay,
    output logic request_ack,
    output logic sleep_state_a_in,
    output logic sleep_state_b_in
);
    int wait_cnt = 0;
    assign sleep_state_a_in = sleep_code >= 3'h3;
    assign sleep_state_b_in = sleep_code >= 3'h4;
    // One ack pulse a chosen time after the request falls
    always @(posedge clock) begin
        request_ack <= power_up_request ? 1'b0 : wait_cnt == ack_delay;
        wait_cnt <= power_up_request ? 0 : wait_cnt + 1;
    end
endmodule
`default_nettype wire

// ==== tb/wpb_top_tb.sv ====
// Self-checking bench for the wake and power control block
`timescale 1ns/10ps
`default_nettype none
module wpb_top_tb;
    typedef struct {logic [2:0] sel; int tog; logic [2:0] slp;} wpb_row_type;
    wpb_row_type rows[7] = '{'{3'h0, 0, 3'h0}, '{3'h1, 4, 3'h1},
        '{3'h2, 8, 3'h2}, '{3'h3, 16, 3'h3}, '{3'h4, 64, 3'h4},
        '{3'h5, 0, 3'h5}, '{3'h7, 0, 3'h0}};
    logic clock = 1'b0, rst = 1'b1, supply_on_polarity_strap = 1'b0;
    logic pin_config_strap_a = 1'b0, pin_config_strap_b = 1'b0;
    logic button_in = 1'b1, ring_in = 1'b1, standby_in_pin = 1'b0;
    logic supply_enable = 1'b0, request_ack, sleep_state_a_in;
    logic sleep_state_b_in, blink_out_a, blink_out_b, button_out;
    logic supply_on_out, supply_on_oe, power_up_request, standby_out_a;
    logic standby_out_b, standby_in, sleep_a, sleep_b, power_mode, la, lb;
    logic [2:0] blink_sel_a = 3'h0, blink_sel_b = 3'h0, sleep_code = 3'h0;
    logic [1:0] standby_out_value = 2'h0;
    int err_count = 0, checks = 0, cycles = 0, ack_delay = 30;
    int ta = 0, tb = 0, sa, sb;
    wpb_top #(.DEBOUNCE_CYCLES(16), .HALF_PERIOD_CYCLES(4),
        .RING_WINDOW_CYCLES(100)) wpb_top_i (.*);
    wpb_chipset_model wpb_chipset_model_i (.*);
    always #2 clock = ~clock;
    always @(posedge clock) begin
        la <= blink_out_a;
        lb <= blink_out_b;
        ta <= ta + int'(la != blink_out_a);
        tb <= tb + int'(lb != blink_out_b);
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            results();
        end
    end
    task automatic results();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic check(string name, logic exp, logic got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s expected %b seen %b", name, exp, got);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic restart(logic pol, logic pa);
        @(posedge clock);
        rst <= 1'b1;
        supply_on_polarity_strap <= pol;
        pin_config_strap_a <= pa;
        tick(10);
        @(posedge clock);
        rst <= 1'b0;
        tick(8);
    endtask
    task automatic ring_train(int gap);
        repeat (3) begin
            @(posedge clock);
            ring_in <= 1'b0;
            tick(4);
            @(posedge clock);
            ring_in <= 1'b1;
            tick(gap);
        end
    endtask
    task automatic press(int n);
        @(posedge clock);
        button_in <= 1'b0;
        tick(n);
        @(posedge clock);
        button_in <= 1'b1;
        #1;
    endtask
    initial begin
        restart(1'b0, 1'b0);
        check("request", 1'b1, power_up_request);
        check("button", 1'b1, button_out);
        foreach (rows[i]) begin
            @(posedge clock);
            blink_sel_a <= rows[i].sel;
            blink_sel_b <= rows[i].sel;
            sleep_code <= rows[i].slp;
            tick(8);
            sa = ta;
            sb = tb;
            tick(256);
            check("rate a", 1'b1, ta-sa-rows[i].tog inside {[-1:1]});
            check("rate b", 1'b1, tb-sb-rows[i].tog inside {[-1:1]});
            if (rows[i].tog == 0) begin
                check("level", rows[i].sel == 3'h5, blink_out_a);
            end else begin
                check("pair", blink_out_b, blink_out_a);
            end
            check("sleep a", rows[i].slp >= 3'h3, sleep_a);
            check("sleep b", rows[i].slp >= 3'h4, sleep_b);
            $display("test blink row %0d done", i);
        end
        press(8);
        tick(30);
        check("glitch", 1'b1, button_out);
        press(40);
        check("pressed", 1'b0, button_out);
        tick(40);
        check("released", 1'b1, button_out);
        $display("test button done");
        ring_train(60);
        tick(200);
        check("slow ring", 1'b1, power_up_request);
        ring_train(10);
        check("wake", 1'b0, power_up_request);
        tick(10);
        check("held", 1'b0, power_up_request);
        tick(40);
        check("acked", 1'b1, power_up_request);
        $display("test ring done");
        check("idle oe", 1'b0, supply_on_oe);
        @(posedge clock);
        supply_enable <= 1'b1;
        tick(8);
        check("low oe", 1'b1, supply_on_oe);
        check("low out", 1'b0, supply_on_out);
        restart(1'b1, 1'b0);
        check("mode", 1'b1, power_mode);
        check("high out", 1'b1, supply_on_out);
        check("high oe", 1'b1, supply_on_oe);
        restart(1'b0, 1'b1);
        check("pin oe", 1'b0, supply_on_oe);
        check("pin button", 1'b1, button_out);
        @(posedge clock);
        standby_out_value <= 2'h2;
        standby_in_pin <= 1'b1;
        sleep_code <= 3'h5;
        tick(8);
        check("standby a", 1'b0, standby_out_a);
        check("standby b", 1'b1, standby_out_b);
        check("standby in", 1'b1, standby_in);
        check("pin sleep a", 1'b1, sleep_a);
        check("pin sleep b", 1'b0, sleep_b);
        $display("test supply done");
        results();
    end
endmodule
bind wpb_top wpb_check #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) wpb_check_i (.*);
`default_nettype wire
